/* hdl/rcgu_device.sv */
// Functional notes
// - low reset input restores register defaults
// - device resets itself after power-up
// - key write to 0x4F causes software reset
// - any reset sets reset-occurred event flag
// - trigger without gating enable never gates
// - host triggers manual gating at any velocity
// - trigger 0x7 loads counter from delay register
// - gate clock when delay counter reaches zero
// - zero delay gates right after trigger
// - high step input wakes the device
// - host wake sequence ends with enable cleared
// - standby entered after standby delay at rest
// - standby entry starts gating delay counter
// - wake shortly before start delay expires
// - bit 17 enables clock gating
// - bit 18 enables gating in standby
module rcgu_device
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    rcgu_spi_if.dev          spi,
    input  wire logic        step_input_wake_pin,
    input  wire logic [1:0]  velocity_state_flags,
    input  wire logic        standby_enable,
    input  wire logic        start_delay_active,
    input  wire logic [31:0] start_delay_remaining,
    output logic             core_clk_en,
    output logic             gated,
    output logic             standby_phase,
    output logic             reset_occurred_flag,
    output logic [31:0]      general_configuration
);
    // --------------------------------------------------------------------
    // power-on stretch and internal reset
    // --------------------------------------------------------------------
    logic [7:0]  por_cnt_q;
    logic        soft_rst_q;
    wire  logic  por_busy = (por_cnt_q != 8'h00);
    wire  logic  rst_int  = por_busy | soft_rst_q;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            por_cnt_q <= 8'(rcgu_pkg::POR_CYCLES);
        else if (por_busy)
            por_cnt_q <= por_cnt_q - 8'h01;
    end
    // --------------------------------------------------------------------
    // serial receiver
    // --------------------------------------------------------------------
    logic        sclk_q;
    logic [5:0]  bit_cnt_q;
    logic [39:0] rx_q;
    logic [31:0] tx_q;
    logic        miso_q;
    logic        cs_n_q;
    wire  logic  sck_rise = spi.sclk & ~sclk_q & ~spi.cs_n;
    wire  logic  sck_fall = ~spi.sclk & sclk_q & ~spi.cs_n;
    wire  logic  frame_end = spi.cs_n & ~cs_n_q;
    wire  logic  frame_ok = frame_end & (bit_cnt_q == rcgu_pkg::FRAME_FULL);
    wire  logic  wr_en    = frame_ok & rx_q[39] & ~rst_int;
    wire  logic [6:0]  wr_addr = rx_q[38:32];
    wire  logic [31:0] wr_data = rx_q[31:0];
    wire  logic [6:0]  rd_addr = {rx_q[5:0], spi.mosi};
    wire  logic  header_done = sck_rise & (bit_cnt_q == rcgu_pkg::HEADER_LAST);
    wire  logic  rd_event_flag_register = header_done & ~rx_q[6]
                          & (rd_addr == rcgu_pkg::ADDR_EVENT_FLAGS);
    assign spi.miso = miso_q;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclk_q    <= 1'b0;
            cs_n_q    <= 1'b1;
            bit_cnt_q <= 6'h00;
            rx_q      <= 40'h0000000000;
        end
        else
        begin
            sclk_q <= spi.sclk;
            cs_n_q <= spi.cs_n;
            if (spi.cs_n)
                bit_cnt_q <= 6'h00;
            else if (sck_rise)
            begin
                bit_cnt_q <= bit_cnt_q + 6'h01;
                rx_q      <= {rx_q[38:0], spi.mosi};
            end
        end
    end
    // --------------------------------------------------------------------
    // register write decode, reset event flag cleared by reading it
    // --------------------------------------------------------------------
    logic [31:0] gen_conf_q;
    logic [31:0] gate_delay_q;
    logic [31:0] stby_delay_q;
    logic [2:0]  trigger_q;
    logic        flag_q;
    wire  logic  wr_gen   = wr_en & (wr_addr == rcgu_pkg::ADDR_GENERAL_CONFIGURATION);
    wire  logic  wr_gdly  = wr_en & (wr_addr == rcgu_pkg::ADDR_GATING_DELAY);
    wire  logic  wr_sdly  = wr_en & (wr_addr == rcgu_pkg::ADDR_STANDBY_DELAY);
    wire  logic  wr_rg    = wr_en & (wr_addr == rcgu_pkg::ADDR_RESET_GATING);
    wire  logic  key_hit  = wr_rg & (wr_data[31:rcgu_pkg::KEY_LSB]
                                     == rcgu_pkg::SOFT_RESET_KEY);
    wire  logic  wr_trig  = wr_rg & ~key_hit;
    wire  logic  trig_go  = wr_trig
                          & (wr_data[2:0] == rcgu_pkg::GATING_TRIGGER);
    wire  logic  gate_en  = gen_conf_q[rcgu_pkg::GATING_EN_BIT];
    wire  logic  stdby_ge = gen_conf_q[rcgu_pkg::GATING_STDBY_EN_BIT];

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gen_conf_q   <= rcgu_pkg::GENERAL_CONFIGURATION_RESET;
            gate_delay_q <= rcgu_pkg::GATING_DELAY_RESET;
            stby_delay_q <= rcgu_pkg::STANDBY_DELAY_RESET;
            trigger_q    <= rcgu_pkg::TRIGGER_RESET;
            soft_rst_q   <= 1'b0;
            flag_q       <= 1'b1;
        end
        else if (rst_int)
        begin
            gen_conf_q   <= rcgu_pkg::GENERAL_CONFIGURATION_RESET;
            gate_delay_q <= rcgu_pkg::GATING_DELAY_RESET;
            stby_delay_q <= rcgu_pkg::STANDBY_DELAY_RESET;
            trigger_q    <= rcgu_pkg::TRIGGER_RESET;
            soft_rst_q   <= 1'b0;
            flag_q       <= 1'b1;
        end
        else
        begin
            soft_rst_q <= key_hit;
            if (rd_event_flag_register)
                flag_q <= 1'b0;
            if (wr_gen)
                gen_conf_q <= wr_data;
            if (wr_gdly)
                gate_delay_q <= wr_data;
            if (wr_sdly)
                stby_delay_q <= wr_data;
            if (wr_trig)
                trigger_q <= wr_data[2:0];
        end
    end

    // --------------------------------------------------------------------
    // standby timer
    // --------------------------------------------------------------------
    logic [31:0] stby_cnt_q;
    logic        standby_q;
    wire  logic  at_rest     = (velocity_state_flags == 2'h0);
    wire  logic  stby_arm    = standby_enable & at_rest & ~rst_int;
    wire  logic  stby_expire = stby_arm & ~standby_q
                             & (stby_cnt_q >= stby_delay_q);
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stby_cnt_q <= 32'h00000000;
            standby_q  <= 1'b0;
        end
        else if (!stby_arm)
        begin
            stby_cnt_q <= 32'h00000000;
            standby_q  <= 1'b0;
        end
        else if (stby_expire)
            standby_q <= 1'b1;
        else if (!standby_q)
            stby_cnt_q <= stby_cnt_q + 32'h00000001;
    end

    // --------------------------------------------------------------------
    // gating delay counter and gated state
    // --------------------------------------------------------------------
    logic [31:0] gate_cnt_q;
    logic        counting_q;
    logic        gated_q;
    wire  logic  near_start = start_delay_active
                            & (start_delay_remaining <= rcgu_pkg::WAKE_MARGIN);
    wire  logic  wake       = step_input_wake_pin | ~gate_en
                            | near_start | rst_int;
    wire  logic  stby_start = stby_expire & stdby_ge;
    wire  logic  start_gate = (trig_go | stby_start) & gate_en;
    wire  logic  cancel     = wr_trig & ~trig_go;
    wire  logic  cnt_done   = counting_q & (gate_cnt_q <= 32'h00000001);
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gate_cnt_q <= 32'h00000000;
            counting_q <= 1'b0;
            gated_q    <= 1'b0;
        end
        else if (wake)
        begin
            gate_cnt_q <= 32'h00000000;
            counting_q <= 1'b0;
            gated_q    <= 1'b0;
        end
        else if (start_gate && !gated_q)
        begin
            gate_cnt_q <= gate_delay_q;
            counting_q <= (gate_delay_q != 32'h00000000);
            gated_q    <= (gate_delay_q == 32'h00000000);
        end
        else if (cancel)
        begin
            gate_cnt_q <= 32'h00000000;
            counting_q <= 1'b0;
        end
        else if (cnt_done)
        begin
            gate_cnt_q <= 32'h00000000;
            counting_q <= 1'b0;
            gated_q    <= 1'b1;
        end
        else if (counting_q)
            gate_cnt_q <= gate_cnt_q - 32'h00000001;
    end

    // --------------------------------------------------------------------
    // register read path, kept alive while gated
    // --------------------------------------------------------------------
    logic [31:0] rd_data;
    always_comb
    begin
        case (rd_addr)
            rcgu_pkg::ADDR_GENERAL_CONFIGURATION:  rd_data = gen_conf_q;
            rcgu_pkg::ADDR_EVENT_FLAGS:   rd_data = {flag_q, 31'h00000000};
            rcgu_pkg::ADDR_GATE_STATUS:   rd_data = {29'h00000000, counting_q,
                                                     standby_q, gated_q};
            rcgu_pkg::ADDR_GATING_DELAY:  rd_data = gate_delay_q;
            rcgu_pkg::ADDR_STANDBY_DELAY: rd_data = stby_delay_q;
            rcgu_pkg::ADDR_RESET_GATING:  rd_data = {29'h00000000, trigger_q};
            default:                      rd_data = 32'h00000000;
        endcase
    end
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_q   <= 32'h00000000;
            miso_q <= 1'b0;
        end
        else if (header_done)
            tx_q <= rd_data;
        else if (sck_fall && bit_cnt_q >= rcgu_pkg::FRAME_FULL - 6'h20)
        begin
            miso_q <= tx_q[31];
            tx_q   <= {tx_q[30:0], 1'b0};
        end
    end

    // --------------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------------
    assign core_clk_en           = ~gated_q;
    assign gated                 = gated_q;
    assign standby_phase         = standby_q;
    assign reset_occurred_flag   = flag_q;
    assign general_configuration = gen_conf_q;

endmodule : rcgu_device

/* hdl/rcgu_host.sv */
module rcgu_host
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    rcgu_spi_if.host         spi,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [6:0]  cmd_addr,
    input  wire logic [31:0] cmd_wdata,
    output logic             cmd_ready,
    output logic             rsp_valid,
    output logic [31:0]      rsp_rdata
);

    // --------------------------------------------------------------------
    // serial clock enable divider
    // --------------------------------------------------------------------
    rcgu_pkg::rcgu_host_state_t state_q;
    logic [7:0]  div_q;
    wire  logic  tick = (div_q == 8'(rcgu_pkg::SCK_HALF_CYCLES - 1));

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            div_q <= 8'h00;
        else if (tick || state_q == rcgu_pkg::RCGU_IDLE)
            div_q <= 8'h00;
        else
            div_q <= div_q + 8'h01;
    end

    // --------------------------------------------------------------------
    // frame sequencer
    // --------------------------------------------------------------------
    logic        sclk_q;
    logic        cs_n_q;
    logic        mosi_q;
    logic [39:0] sh_q;
    logic [31:0] rx_q;
    logic [5:0]  cnt_q;
    logic        rsp_q;
    logic [31:0] rdata_q;

    assign cmd_ready = (state_q == rcgu_pkg::RCGU_IDLE);
    assign spi.sclk  = sclk_q;
    assign spi.cs_n  = cs_n_q;
    assign spi.mosi  = mosi_q;
    assign rsp_valid = rsp_q;
    assign rsp_rdata = rdata_q;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= rcgu_pkg::RCGU_IDLE;
            sclk_q  <= 1'b0;
            cs_n_q  <= 1'b1;
            mosi_q  <= 1'b0;
            sh_q    <= 40'h0000000000;
            rx_q    <= 32'h00000000;
            cnt_q   <= 6'h00;
            rsp_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            rsp_q <= 1'b0;
            case (state_q)
                rcgu_pkg::RCGU_IDLE:
                begin
                    if (cmd_valid)
                    begin
                        sh_q    <= {cmd_write, cmd_addr, cmd_wdata};
                        mosi_q  <= cmd_write;
                        cs_n_q  <= 1'b0;
                        cnt_q   <= 6'h00;
                        state_q <= rcgu_pkg::RCGU_SHIFT;
                    end
                end
                rcgu_pkg::RCGU_SHIFT:
                begin
                    if (tick && !sclk_q)
                    begin
                        sclk_q <= 1'b1;
                        rx_q   <= {rx_q[30:0], spi.miso};
                    end
                    else if (tick)
                    begin
                        sclk_q <= 1'b0;
                        cnt_q  <= cnt_q + 6'h01;
                        sh_q   <= {sh_q[38:0], 1'b0};
                        mosi_q <= sh_q[38];
                        if (cnt_q == rcgu_pkg::FRAME_LAST)
                            state_q <= rcgu_pkg::RCGU_HOLD;
                    end
                end
                rcgu_pkg::RCGU_HOLD:
                begin
                    if (tick)
                    begin
                        cs_n_q  <= 1'b1;
                        rsp_q   <= 1'b1;
                        rdata_q <= rx_q;
                        state_q <= rcgu_pkg::RCGU_IDLE;
                    end
                end
                default:
                    state_q <= rcgu_pkg::RCGU_IDLE;
            endcase
        end
    end

endmodule : rcgu_host

/* hdl/rcgu_pkg.sv */
package rcgu_pkg;

    // --------------------------------------------------------------------
    // register addresses
    // --------------------------------------------------------------------
    localparam logic [6:0]  ADDR_GENERAL_CONFIGURATION   = 7'h00;
    localparam logic [6:0]  ADDR_EVENT_FLAGS    = 7'h0E;
    localparam logic [6:0]  ADDR_GATE_STATUS    = 7'h0F;
    localparam logic [6:0]  ADDR_GATING_DELAY   = 7'h14;
    localparam logic [6:0]  ADDR_STANDBY_DELAY  = 7'h15;
    localparam logic [6:0]  ADDR_RESET_GATING   = 7'h4F;

    // --------------------------------------------------------------------
    // fields and reset values
    // --------------------------------------------------------------------
    localparam int          GATING_EN_BIT       = 17;
    localparam int          GATING_STDBY_EN_BIT = 18;
    localparam int          RESET_FLAG_BIT      = 31;
    localparam int          KEY_LSB             = 8;
    localparam logic [23:0] SOFT_RESET_KEY      = 24'h525354;
    localparam logic [2:0]  GATING_TRIGGER      = 3'h7;
    localparam logic [31:0] GENERAL_CONFIGURATION_RESET  = 32'h00006020;
    localparam logic [31:0] GATING_DELAY_RESET  = 32'h00000000;
    localparam logic [31:0] STANDBY_DELAY_RESET = 32'h00000000;
    localparam logic [2:0]  TRIGGER_RESET       = 3'h0;

    // --------------------------------------------------------------------
    // serial frame layout
    // --------------------------------------------------------------------
    localparam int          FRAME_BITS          = 40;
    localparam int          HEADER_BITS         = 8;
    localparam logic [5:0]  FRAME_LAST          = 6'h27;
    localparam logic [5:0]  HEADER_LAST         = 6'h07;
    localparam logic [5:0]  FRAME_FULL          = 6'h28;

    // --------------------------------------------------------------------
    // timing
    // --------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS       = 10;
    localparam int          SCK_HALF_NS         = 40;
    localparam int          SCK_HALF_CYCLES     =
        (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          POR_NS              = 1000;
    localparam int          POR_CYCLES          =
        (POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [31:0] WAKE_MARGIN         = 32'h00000010;

    typedef enum logic [1:0]
    {
        RCGU_IDLE  = 2'h0,
        RCGU_SHIFT = 2'h1,
        RCGU_HOLD  = 2'h3
    } rcgu_host_state_t;

endpackage : rcgu_pkg

/* hdl/rcgu_spi_if.sv */
interface rcgu_spi_if;

    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;

    modport dev
    (
        input  sclk,
        input  cs_n,
        input  mosi,
        output miso
    );

    modport host
    (
        output sclk,
        output cs_n,
        output mosi,
        input  miso
    );

endinterface : rcgu_spi_if

/* tb/rcgu_properties.sv */
module rcgu_properties
(
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic        step_input_wake_pin,
    input wire logic        start_delay_active,
    input wire logic [31:0] start_delay_remaining,
    input wire logic        core_clk_en,
    input wire logic        gated,
    input wire logic        reset_occurred_flag,
    input wire logic [31:0] general_configuration
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // gating, reset and serial frame relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    a_clock_follows_gate: assert property (
        !core_clk_en |-> gated && !$past(step_input_wake_pin))
        else $error("core clock stopped while not gated or after wake");
    a_step_pin_wakes: assert property (
        step_input_wake_pin |=> !gated)
        else $error("gated state survived a high step input");
    a_enable_low_wakes: assert property (
        !general_configuration[17] |=> !gated)
        else $error("gated while gating enable is low");
    a_start_delay_wakes: assert property (
        start_delay_active && start_delay_remaining <= 32'h00000010
        |=> !gated)
        else $error("gated state kept near start delay expiry");
    a_gate_needs_enable: assert property (
        $rose(gated) |-> $past(general_configuration[17]))
        else $error("gating began without the enable bit");
    a_reset_flag_held: assert property (
        $rose(reset_n) |-> reset_occurred_flag [*8])
        else $error("reset flag not set after reset");
    a_reset_defaults: assert property (
        $rose(reset_n) |-> (general_configuration ==
        rcgu_pkg::GENERAL_CONFIGURATION_RESET && !gated) [*8])
        else $error("registers not at defaults after reset");
    a_frame_closes: assert property (
        $fell(cs_n) |-> ##[300:340] $rose(cs_n))
        else $error("serial frame did not close in time");
    a_sclk_idle_low: assert property (
        cs_n |-> !sclk)
        else $error("serial clock not low outside a frame");

endmodule : rcgu_properties

/* tb/reset_and_clock_gating_unit_tb.sv */
module reset_and_clock_gating_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------
    localparam logic [31:0] GC  = rcgu_pkg::GENERAL_CONFIGURATION_RESET;
    localparam logic [6:0]  GCA = rcgu_pkg::ADDR_GENERAL_CONFIGURATION;
    localparam logic [6:0]  DLY = rcgu_pkg::ADDR_GATING_DELAY;
    localparam logic [6:0]  SBY = rcgu_pkg::ADDR_STANDBY_DELAY;
    localparam logic [6:0]  TRG = rcgu_pkg::ADDR_RESET_GATING;
    localparam logic [6:0]  EVF = rcgu_pkg::ADDR_EVENT_FLAGS;
    logic        sys_clk;
    logic        reset_n;
    logic        cmd_valid;
    logic        cmd_write;
    logic [6:0]  cmd_addr;
    logic [31:0] cmd_wdata;
    logic        cmd_ready;
    logic        rsp_valid;
    logic [31:0] rsp_rdata;
    logic        step_pin;
    logic [1:0]  vel_flags;
    logic        stby_en;
    logic        sd_act;
    logic [31:0] sd_rem;
    logic        clk_en;
    logic        gated;
    logic        stby_ph;
    logic        rst_flag;
    logic [31:0] gcfg;
    int          fail_count;
    int          check_count;

    rcgu_spi_if spi_if ();

    rcgu_device rcgu_device_inst
    (
        .sys_clk               (sys_clk),
        .reset_n               (reset_n),
        .spi                   (spi_if.dev),
        .step_input_wake_pin   (step_pin),
        .velocity_state_flags  (vel_flags),
        .standby_enable        (stby_en),
        .start_delay_active    (sd_act),
        .start_delay_remaining (sd_rem),
        .core_clk_en           (clk_en),
        .gated                 (gated),
        .standby_phase         (stby_ph),
        .reset_occurred_flag   (rst_flag),
        .general_configuration (gcfg)
    );

    rcgu_host rcgu_host_inst
    (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .spi       (spi_if.host),
        .cmd_valid (cmd_valid),
        .cmd_write (cmd_write),
        .cmd_addr  (cmd_addr),
        .cmd_wdata (cmd_wdata),
        .cmd_ready (cmd_ready),
        .rsp_valid (rsp_valid),
        .rsp_rdata (rsp_rdata)
    );

    rcgu_properties rcgu_properties_inst
    (
        .sys_clk               (sys_clk),
        .reset_n               (reset_n),
        .sclk                  (spi_if.sclk),
        .cs_n                  (spi_if.cs_n),
        .step_input_wake_pin   (step_pin),
        .start_delay_active    (sd_act),
        .start_delay_remaining (sd_rem),
        .core_clk_en           (clk_en),
        .gated                 (gated),
        .reset_occurred_flag   (rst_flag),
        .general_configuration (gcfg)
    );

    always #5 sys_clk = ~sys_clk;

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic chk1(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask : chk1

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : idle

    task automatic xfer(input logic w, input logic [6:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        int n;
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_addr  = a;
        cmd_wdata = d;
        while (cmd_ready !== 1'b1)
            @(negedge sys_clk);
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 1000)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 1000)
            check(32'h0, 32'h1);
        r = rsp_rdata;
    endtask : xfer

    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        check(r, e);
    endtask : rd

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    initial
    begin
        #200000;
        fail_count++;
        final_report();
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 7'h00;
        cmd_wdata = 32'h0;
        step_pin = 1'b0;
        vel_flags = 2'h1;
        stby_en = 1'b0;
        sd_act = 1'b0;
        sd_rem = 32'h0;
        fail_count = 0;
        check_count = 0;
        repeat (4) @(negedge sys_clk);
        check(gcfg, GC);
        chk1(rst_flag, 1'b1);
        reset_n = 1'b1;
        idle(110);
        chk1(rst_flag, 1'b1);
        rd(EVF, 32'h80000000);
        rd(EVF, 32'h0);
        rd(GCA, GC);
        rd(7'h33, 32'h0);
        vel_flags = 2'h0;
        wr(DLY, 32'h5);
        wr(TRG, 32'h7);
        idle(20);
        chk1(gated, 1'b0);
        rd(TRG, 32'h7);
        wr(GCA, GC | 32'h00020000);
        wr(TRG, 32'h0);
        wr(TRG, 32'h7);
        idle(2);
        chk1(gated, 1'b0);
        idle(10);
        chk1(clk_en, 1'b0);
        rd(rcgu_pkg::ADDR_GATE_STATUS, 32'h1);
        step_pin = 1'b1;
        idle(2);
        chk1(gated, 1'b0);
        step_pin = 1'b0;
        wr(DLY, 32'h0);
        wr(TRG, 32'h0);
        wr(TRG, 32'h7);
        idle(3);
        chk1(gated, 1'b1);
        wr(DLY, 32'h0FFFFFFF);
        wr(TRG, 32'h0);
        wr(TRG, 32'h7);
        chk1(gated, 1'b1);
        wr(GCA, GC);
        idle(2);
        chk1(gated, 1'b0);
        wr(GCA, GC | 32'h00020000);
        idle(30);
        chk1(gated, 1'b0);
        wr(DLY, 32'h14);
        wr(TRG, 32'h0);
        wr(TRG, 32'h7);
        idle(2);
        step_pin = 1'b1;
        idle(1);
        step_pin = 1'b0;
        idle(30);
        chk1(gated, 1'b0);
        wr(TRG, 32'h0);
        wr(TRG, 32'h7);
        idle(10);
        chk1(gated, 1'b0);
        idle(20);
        chk1(gated, 1'b1);
        sd_act = 1'b1;
        sd_rem = 32'h11;
        idle(3);
        chk1(gated, 1'b1);
        sd_rem = 32'h10;
        idle(2);
        chk1(gated, 1'b0);
        sd_act = 1'b0;
        vel_flags = 2'h1;
        wr(SBY, 32'h8);
        stby_en = 1'b1;
        idle(20);
        chk1(stby_ph, 1'b0);
        vel_flags = 2'h0;
        idle(20);
        chk1(stby_ph, 1'b1);
        chk1(gated, 1'b0);
        stby_en = 1'b0;
        wr(TRG, 32'h52535400);
        idle(110);
        check(gcfg, GC);
        chk1(rst_flag, 1'b1);
        rd(SBY, 32'h0);
        wr(DLY, 32'h4);
        wr(SBY, 32'h8);
        wr(GCA, GC | 32'h00060000);
        stby_en = 1'b1;
        idle(30);
        chk1(stby_ph, 1'b1);
        chk1(gated, 1'b1);
        step_pin = 1'b1;
        idle(2);
        chk1(gated, 1'b0);
        step_pin = 1'b0;
        reset_n = 1'b0;
        idle(2);
        check(gcfg, GC);
        chk1(gated, 1'b0);
        reset_n = 1'b1;
        idle(110);
        final_report();
    end

endmodule : reset_and_clock_gating_unit_tb
